// *** logic/interval_timer_params.svh ***
// Constants of the interval timer: register indices, field positions, reset values.
// Assumes byte address = index * 4 on a 32-bit AXI4-Lite bus.
`ifndef INTERVAL_TIMER_PARAMS_SVH
`define INTERVAL_TIMER_PARAMS_SVH

`define IT_ADDR_W 16
`define IT_DATA_W 32
`define IT_INDEX_W 14
`define IT_GATE_INDEX 14'h0f76
`define IT_CTRL_INDEX 14'h0fc8
`define IT_STATUS_INDEX 14'h0fd0
`define IT_MASK_INDEX 14'h0fd1
`define IT_GATE_RESET 8'h00
`define IT_CTRL_RESET 4'h0
`define IT_GATE_EN_BIT 5
`define IT_SERIAL_EN_BIT 0
`define IT_RUN_BIT 0
`define IT_SEL_LSB 1
`define IT_SEL_MSB 3
`define IT_SEL_W 3
`define IT_COUNT_W 15
`define IT_FULL_MASK 15'h7fff
`define IT_STAT_W 2
`define IT_STAT_PERIODIC_BIT 0
`define IT_STAT_AUTOSTOP_BIT 1
`define IT_STAT_RESET 2'h0
`define IT_RESP_OKAY 2'h0
`define IT_RESP_SLVERR 2'h2

`endif

// *** logic/interval_timer_pkg.sv ***
// Types shared by the interval timer modules.
// Assumes the constants header is on the include path.
`include "interval_timer_params.svh"

package interval_timer_pkg;

  // Control register layout: select in bits 3:1, run in bit 0.
  typedef struct packed {
    logic [`IT_SEL_W-1:0] select;
    logic run;
  } ctrl_type;

  // A write request held until both address and data are taken.
  typedef struct packed {
    logic [`IT_ADDR_W-1:0] addr;
    logic [`IT_DATA_W-1:0] data;
    logic [3:0] strb;
  } wr_req_type;

  // A read answer.
  typedef struct packed {
    logic [1:0] resp;
    logic [`IT_DATA_W-1:0] data;
  } rd_ans_type;

endpackage

// *** logic/level_sync.sv ***
// Three-stage synchroniser with an agreement filter and a rising-edge pulse.
// Assumes an input asynchronous to i_clk.
`timescale 1ns/1ps
`include "interval_timer_params.svh"

module level_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_reg;
  logic rise_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      if (stage2_reg == stage3_reg) begin
        level_reg <= stage3_reg;
      end
      rise_reg <= (stage2_reg == stage3_reg) && stage3_reg && !level_reg;
    end
  end

  assign o_level = level_reg;
  assign o_rise = rise_reg;

endmodule // level_sync

// *** logic/interval_counter.sv ***
// Binary counter of low-frequency ticks with a power-of-two interval event.
// Assumes i_tick is a one-cycle pulse per low-frequency clock rise.
`timescale 1ns/1ps
`include "interval_timer_params.svh"

module interval_counter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [`IT_SEL_W-1:0] i_select,
  output logic o_event
);

  logic [`IT_COUNT_W-1:0] count_reg;
  logic [`IT_COUNT_W-1:0] interval_mask;
  logic event_reg;

  // Code 0 gives 2^15 ticks, each step halves it, code 7 gives 2^8.
  assign interval_mask = `IT_FULL_MASK >> i_select; // RULE1

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= '0;
    end else if (!i_run) begin
      count_reg <= '0; // RULE12
    end else if (i_tick) begin
      count_reg <= count_reg + `IT_COUNT_W'(1); // RULE10 RULE11
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_reg <= 1'b0;
    end else begin
      event_reg <= i_run && i_tick && ((count_reg & interval_mask) == interval_mask); // RULE11
    end
  end

  assign o_event = event_reg;

  a_count_cleared: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
    !i_run |=> count_reg == '0)
    else $error("counter not cleared while stopped");

  a_count_advance: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
    i_run && i_tick ##1 i_run |-> count_reg == $past(count_reg) + `IT_COUNT_W'(1))
    else $error("counter did not advance on a tick");

  a_event_interval: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    $rose(event_reg) |-> ($past(count_reg) & $past(interval_mask)) == $past(interval_mask))
    else $error("interval event at wrong count");

endmodule // interval_counter

// *** logic/interval_timer.sv ***
// Periodic interval timer with an AXI4-Lite register slave and interrupt logic.
// Assumes mode inputs come from logic on i_clk; the low-frequency clock is asynchronous.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "interval_timer_params.svh"

// Functional notes
// [RULE1] Select code 0 gives 2^15 ticks per event, each step halves, code 7 gives 2^8.
// [RULE2] Writes to the select field are ignored while the run bit is set.
// [RULE3] Starting run loads select in the same write; stopping run keeps select.
// [RULE4] Oscillator off, stop or tick-only sleep clears run and keeps select.
// [RULE5] Gate enable at zero stops the block; at one it operates.
// [RULE6] Gate enable resets to zero.
// [RULE7] Software sets the gate enable before first touching the control register.
// [RULE8] Software must not clear the gate enable while running.
// [RULE9] Run is zero after reset; the control register resets to zero.
// [RULE10] Setting run starts the counter on low-frequency ticks.
// [RULE11] At each interval an event is raised and counting continues.
// [RULE12] Clearing run clears the counter and stops it.
// [RULE13] Operation only in modes where the low-frequency clock runs.
// [RULE14] The periodic request leaves as a single system-clock pulse.
module interval_timer (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [`IT_ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [`IT_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [`IT_ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [`IT_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_low_frequency_clock,
  input wire logic i_low_oscillator_enable,
  input wire logic i_stop_mode,
  input wire logic i_tick_only_low_clock_sleep,
  output logic o_periodic_interrupt_request,
  output logic o_irq,
  output logic o_serial_port0_clock_gate_enable
);

  // ********************************************************************
  // Reset release
  // ********************************************************************

  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];

  // ********************************************************************
  // Write channels
  // ********************************************************************

  interval_timer_pkg::wr_req_type wr_req_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic do_write;
  logic [`IT_INDEX_W-1:0] wr_index;
  logic wr_lane0;
  logic wr_mapped;

  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_index = wr_req_reg.addr[`IT_ADDR_W-1:2];
  assign wr_lane0 = wr_req_reg.strb[0];
  assign wr_mapped = (wr_index == `IT_GATE_INDEX) || (wr_index == `IT_CTRL_INDEX) ||
                     (wr_index == `IT_STATUS_INDEX) || (wr_index == `IT_MASK_INDEX);

  // Address and data are taken in either order and held until the write is done.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_req_reg <= '0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      if (i_awvalid && awready_reg) begin
        wr_req_reg.addr <= i_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end else if (!aw_full_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (i_wvalid && wready_reg) begin
        wr_req_reg.data <= i_wdata;
        wr_req_reg.strb <= i_wstrb;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end else if (!w_full_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `IT_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? `IT_RESP_OKAY : `IT_RESP_SLVERR;
    end else if (bvalid_reg && i_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ********************************************************************
  // Gate, control, status and mask registers
  // ********************************************************************

  logic [7:0] gate_reg;
  interval_timer_pkg::ctrl_type ctrl_reg;
  logic [`IT_STAT_W-1:0] status_reg;
  logic [`IT_STAT_W-1:0] mask_reg;
  logic gate_en;
  logic ctrl_wr;
  logic halt_cond;
  logic cnt_event;
  logic [`IT_STAT_W-1:0] status_set;
  logic [`IT_STAT_W-1:0] status_clr;

  assign gate_en = gate_reg[`IT_GATE_EN_BIT];
  // Without its clock the block takes no control writes.
  assign ctrl_wr = do_write && wr_lane0 && (wr_index == `IT_CTRL_INDEX) && gate_en; // RULE5
  assign halt_cond = !i_low_oscillator_enable || i_stop_mode ||
                     i_tick_only_low_clock_sleep; // RULE13

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg <= `IT_GATE_RESET; // RULE6
    end else if (do_write && wr_lane0 && (wr_index == `IT_GATE_INDEX)) begin
      gate_reg <= wr_req_reg.data[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `IT_CTRL_RESET; // RULE9
    end else if (halt_cond) begin
      ctrl_reg.run <= 1'b0; // RULE4 RULE13
    end else if (ctrl_wr) begin
      if (!ctrl_reg.run) begin
        ctrl_reg.select <= wr_req_reg.data[`IT_SEL_MSB:`IT_SEL_LSB]; // RULE2 RULE3
      end
      ctrl_reg.run <= wr_req_reg.data[`IT_RUN_BIT]; // RULE3
    end
  end

  always_comb begin
    status_set = '0;
    status_set[`IT_STAT_PERIODIC_BIT] = cnt_event;
    status_set[`IT_STAT_AUTOSTOP_BIT] = ctrl_reg.run && halt_cond;
    status_clr = '0;
    if (do_write && wr_lane0 && (wr_index == `IT_STATUS_INDEX)) begin
      status_clr = wr_req_reg.data[`IT_STAT_W-1:0];
    end
  end

  // A new event in the cycle of its clear still sets the bit.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `IT_STAT_RESET;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `IT_STAT_RESET;
    end else if (do_write && wr_lane0 && (wr_index == `IT_MASK_INDEX)) begin
      mask_reg <= wr_req_reg.data[`IT_STAT_W-1:0];
    end
  end

  // ********************************************************************
  // Read channel
  // ********************************************************************

  interval_timer_pkg::rd_ans_type rd_ans;
  logic [`IT_INDEX_W-1:0] rd_index;
  logic arready_reg;
  logic rvalid_reg;
  logic [`IT_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  assign rd_index = i_araddr[`IT_ADDR_W-1:2];

  always_comb begin
    rd_ans.resp = `IT_RESP_OKAY;
    rd_ans.data = '0;
    unique case (rd_index)
      `IT_GATE_INDEX: rd_ans.data[7:0] = gate_reg;
      `IT_CTRL_INDEX: rd_ans.data[`IT_SEL_MSB:0] = ctrl_reg;
      `IT_STATUS_INDEX: rd_ans.data[`IT_STAT_W-1:0] = status_reg;
      `IT_MASK_INDEX: rd_ans.data[`IT_STAT_W-1:0] = mask_reg;
      default: rd_ans.resp = `IT_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `IT_RESP_OKAY;
    end else if (i_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_ans.data;
      rresp_reg <= rd_ans.resp;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // ********************************************************************
  // Low-frequency tick, counter and interrupt outputs
  // ********************************************************************

  logic lf_rise;
  logic request_reg;
  logic irq_reg;

  level_sync lf_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_async(i_low_frequency_clock),
    .o_level(),
    .o_rise(lf_rise)
  );

  // Ticks reach the counter only while the clock gate is open.
  interval_counter counter (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_run(ctrl_reg.run),
    .i_tick(lf_rise && gate_en), // RULE5
    .i_select(ctrl_reg.select),
    .o_event(cnt_event)
  );

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      request_reg <= cnt_event; // RULE14
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_periodic_interrupt_request = request_reg;
  assign o_irq = irq_reg;
  assign o_serial_port0_clock_gate_enable = gate_reg[`IT_SERIAL_EN_BIT];

  // ********************************************************************
  // Assertions
  // ********************************************************************

  sequence start_write;
    ctrl_wr && !ctrl_reg.run && !halt_cond && wr_req_reg.data[`IT_RUN_BIT];
  endsequence

  sequence stop_write;
    ctrl_wr && ctrl_reg.run && !halt_cond && !wr_req_reg.data[`IT_RUN_BIT];
  endsequence

  a_select_locked: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE2
    ctrl_reg.run |=> ctrl_reg.select == $past(ctrl_reg.select))
    else $error("select changed while running");

  a_start_loads_select: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE3
    start_write |=> ctrl_reg.run &&
      ctrl_reg.select == $past(wr_req_reg.data[`IT_SEL_MSB:`IT_SEL_LSB]))
    else $error("start write did not load select");

  a_stop_keeps_select: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE3
    stop_write |=> !ctrl_reg.run && $stable(ctrl_reg.select))
    else $error("stop write altered select");

  a_mode_halt: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE4
    halt_cond |=> !ctrl_reg.run && $stable(ctrl_reg.select))
    else $error("run not cleared on low-clock loss");

  a_gate_blocks: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE5
    !gate_en && !halt_cond |=> $stable(ctrl_reg))
    else $error("control changed with clock gate closed");

  a_reset_values: assert property (@(posedge i_clk) // RULE6 RULE9
    $rose(rst_n) |-> ctrl_reg == '0 && gate_reg == `IT_GATE_RESET)
    else $error("wrong values after reset release");

  a_request_pulse: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE14
    cnt_event |=> o_periodic_interrupt_request ##1 !o_periodic_interrupt_request)
    else $error("request is not a single pulse");

  a_event_keeps_run: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE11
    cnt_event && ctrl_reg.run && !halt_cond && !ctrl_wr |=> ctrl_reg.run)
    else $error("run stopped after an event");

  a_status_sticky: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE11
    cnt_event |=> status_reg[`IT_STAT_PERIODIC_BIT] ##1
      (o_irq || !$past(mask_reg[`IT_STAT_PERIODIC_BIT])))
    else $error("periodic status not set");

endmodule // interval_timer

// *** verif/test_interval_timer.sv ***
// Self-checking bench for the periodic interval timer block.
// Assumes the logic/ files and the constants header are compiled and on the include path.
`timescale 1ns/1ps
`include "interval_timer_params.svh"

module test_interval_timer;
  localparam logic [15:0] GATE_A = {`IT_GATE_INDEX, 2'b00};
  localparam logic [15:0] CTRL_A = {`IT_CTRL_INDEX, 2'b00};
  localparam logic [15:0] STAT_A = {`IT_STATUS_INDEX, 2'b00};
  localparam logic [15:0] MASK_A = {`IT_MASK_INDEX, 2'b00};
  logic i_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [15:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, rd;
  logic [3:0] i_wstrb;
  logic [1:0] rr;
  logic i_lf, i_osc_en, i_stop, i_sleep;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_req, o_irq, o_sio;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int n_errors, n_checks, n_pulses;

  interval_timer i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_low_frequency_clock(i_lf), .i_low_oscillator_enable(i_osc_en),
    .i_stop_mode(i_stop), .i_tick_only_low_clock_sleep(i_sleep),
    .o_periodic_interrupt_request(o_req), .o_irq(o_irq),
    .o_serial_port0_clock_gate_enable(o_sio)
  );

  always #50 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_req === 1'b1) begin
      n_pulses <= n_pulses + 1;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    n_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    final_report();
  endtask

  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    int k;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'h1;
    for (k = 0; k < 200 && !(aw_done && w_done); k++) begin
      @(posedge i_clk);
      if (!aw_done && o_awready === 1'b1) begin
        aw_done = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_done && o_wready === 1'b1) begin
        w_done = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    if (!(aw_done && w_done)) timed_out();
    i_bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge i_clk);
      if (o_bvalid === 1'b1) break;
    end
    if (k == 200) timed_out();
    r = o_bresp;
    i_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    for (k = 0; k < 200; k++) begin
      @(posedge i_clk);
      if (o_arready === 1'b1) break;
    end
    if (k == 200) timed_out();
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge i_clk);
      if (o_rvalid === 1'b1) break;
    end
    if (k == 200) timed_out();
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [15:0] a, input logic [31:0] d);
    axi_write(a, d, rr);
    check32({30'h0, rr}, {30'h0, `IT_RESP_OKAY});
  endtask

  task automatic rd_expect(input logic [15:0] a, input logic [31:0] exp);
    axi_read(a, rd, rr);
    check32(rd, exp);
  endtask

  // Each tick holds the slow clock high four and low four system cycles.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_lf <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_lf <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (8) @(posedge i_clk);
  endtask

  task automatic pulses_over(input int n, input int exp);
    int p0;
    p0 = n_pulses;
    ticks(n);
    check32(32'(n_pulses - p0), 32'(exp));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    rd_expect(GATE_A, 32'h0000_0000);
    rd_expect(CTRL_A, 32'h0000_0000);
    rd_expect(STAT_A, 32'h0000_0000);
    rd_expect(MASK_A, 32'h0000_0000);
    axi_read(16'h0004, rd, rr);
    check32({30'h0, rr}, {30'h0, `IT_RESP_SLVERR});
    axi_write(16'h0004, 32'h0000_00ff, rr);
    check32({30'h0, rr}, {30'h0, `IT_RESP_SLVERR});
  endtask

  task automatic t_gate_off();
    wr_ok(CTRL_A, 32'h0000_000f);
    rd_expect(CTRL_A, 32'h0000_0000);
    pulses_over(300, 0);
    wr_ok(GATE_A, 32'h0000_0021);
    rd_expect(GATE_A, 32'h0000_0021);
    check32({31'h0, o_sio}, 32'h1);
  endtask

  task automatic t_intervals();
    wr_ok(CTRL_A, 32'h0000_000f);
    rd_expect(CTRL_A, 32'h0000_000f);
    wr_ok(CTRL_A, 32'h0000_0003);
    rd_expect(CTRL_A, 32'h0000_000f);
    pulses_over(512, 2);
    wr_ok(CTRL_A, 32'h0000_0000);
    rd_expect(CTRL_A, 32'h0000_000e);
    wr_ok(CTRL_A, 32'h0000_000d);
    pulses_over(1024, 2);
    wr_ok(CTRL_A, 32'h0000_0000);
    wr_ok(CTRL_A, 32'h0000_000b);
    pulses_over(1023, 0);
    pulses_over(1, 1);
  endtask

  task automatic t_stop_restart();
    pulses_over(100, 0);
    wr_ok(CTRL_A, 32'h0000_0000);
    wr_ok(CTRL_A, 32'h0000_000f);
    pulses_over(255, 0);
    pulses_over(1, 1);
  endtask

  task automatic t_irq();
    rd_expect(STAT_A, 32'h0000_0001);
    check32({31'h0, o_irq}, 32'h0);
    wr_ok(MASK_A, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    check32({31'h0, o_irq}, 32'h1);
    wr_ok(STAT_A, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    check32({31'h0, o_irq}, 32'h0);
    rd_expect(STAT_A, 32'h0000_0000);
  endtask

  task automatic t_halt_modes();
    int m;
    for (m = 0; m < 3; m++) begin
      wr_ok(CTRL_A, 32'h0000_000f);
      rd_expect(CTRL_A, 32'h0000_000f);
      @(posedge i_clk);
      i_osc_en <= (m != 0);
      i_stop <= (m == 1);
      i_sleep <= (m == 2);
      repeat (2) @(posedge i_clk);
      i_osc_en <= 1'b1;
      i_stop <= 1'b0;
      i_sleep <= 1'b0;
      rd_expect(CTRL_A, 32'h0000_000e);
      rd_expect(STAT_A, 32'h0000_0002);
      wr_ok(STAT_A, 32'h0000_0003);
    end
    // The gate is closed only once the timer has stopped.
    wr_ok(GATE_A, 32'h0000_0001);
    wr_ok(CTRL_A, 32'h0000_0001);
    rd_expect(CTRL_A, 32'h0000_000e);
    check32({31'h0, o_sio}, 32'h1);
  endtask

  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_lf} = 6'h00;
    {i_stop, i_sleep} = 2'h0;
    i_osc_en = 1'b1;
    i_awaddr = 16'h0000;
    i_araddr = 16'h0000;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'h0;
    n_errors = 0;
    n_checks = 0;
    n_pulses = 0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset_values();
    t_gate_off();
    t_intervals();
    t_stop_restart();
    t_irq();
    t_halt_modes();
    final_report();
  end
endmodule // test_interval_timer
